/* rtl/lhsu_pkg.sv */
// Constants, register map and state type for the LIN hardware sync unit.
// Summary of operation
// - Edge config bits 7:4 set the stop edge count; reset value 3.
// - Edge config bits 3:0 set the start falling edge count; reset value 2.
// - The falling edge that opens the break is edge number one.
// - Control bit 7 picks rising or falling edges for the stop count.
// - Sync timer is 16-bit, read only, ticking at 5 MHz.
// - Break timer is 12-bit, ticking at 131 kHz; reads return its count.
// - A bus falling edge or a break timer read clears the break timer.
// - Writing the break location loads the 12-bit compare, timer untouched.
// - Timer reaching compare sets status bit 0 and raises the interrupt request.
// - After the break match the break timer runs on until the rising edge.
// - Break timer overflow with bus low sets status bit 4 and interrupt request.
// - Break compare resets to 0x47, eleven bit times at 20 kbps.
// - Sync timing only happens after a valid break match.
// - Break detection stays live while waiting for or receiving data.
// - Config 0x62 times first to fifth sync falling edge; software divides by eight.
// - Edge config register is 8-bit read/write, reset value 0x32.
// - Enable bit turns break and sync functions on; clearing turns them off.
// - Reset bit restores all logic but the other control bits to defaults and self-clears after 15 us.
package lhsu_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register byte addresses
	localparam logic [31:0] ADDR_SYNC_CONTROL = 32'hffff0780;
	localparam logic [31:0] ADDR_SYNC_STATUS  = 32'hffff0784;
	localparam logic [31:0] ADDR_SYNC_TIMER   = 32'hffff0788;
	localparam logic [31:0] ADDR_EDGE_CONFIG  = 32'hffff078c;
	localparam logic [31:0] ADDR_BREAK_TIMER  = 32'hffff0790;

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0]  EDGE_CONFIG_RST = 8'h32;
	localparam logic [11:0] BREAK_CMP_RST   = 12'h047;
	localparam logic [8:0]  CONTROL_RST     = 9'h000;
	localparam logic [5:0]  STATUS_RST      = 6'h00;

	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int STOP_MSB  = 7;
	localparam int STOP_LSB  = 4;
	localparam int START_MSB = 3;
	localparam int START_LSB = 0;

	localparam int CTRL_RST_BIT  = 0;
	localparam int CTRL_EN_BIT   = 1;
	localparam int CTRL_ECLR_BIT = 2;
	localparam int CTRL_POL_BIT  = 7;

	localparam int STA_BREAK_BIT = 0;
	localparam int STA_START_BIT = 1;
	localparam int STA_STOP_BIT  = 2;
	localparam int STA_BFE_BIT   = 4;
	localparam int STA_RDONE_BIT = 5;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int PCLK_HZ      = 40000000;
	localparam int PCLK_NS      = 25;
	localparam int SYNC_CLK_HZ  = 5000000;
	localparam int BRK_CLK_HZ   = 131000;
	localparam int SELF_CLR_NS  = 15000;
	localparam int SYNC_DIV     = PCLK_HZ / SYNC_CLK_HZ;
	localparam int BRK_DIV      = PCLK_HZ / BRK_CLK_HZ;
	localparam int SELF_CLR_CYC = (SELF_CLR_NS + PCLK_NS - 1) / PCLK_NS;

	////////////////////////////////////////////////////////////////////////////
	// Frame tracking states
	typedef enum logic [1:0] {
		LHSU_IDLE,
		LHSU_BREAK,
		LHSU_SYNC_WAIT,
		LHSU_SYNC_RUN
	} lhsu_state_e;

endpackage

/* rtl/lhsu_tick_gen.sv */
// Prescaler that turns pclk into a one-cycle tick at a lower rate.
`timescale 1ns/10ps
module lhsu_tick_gen #(
	parameter int unsigned DIV = 8
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Control
	input  wire logic clr,
	// Tick out
	output logic      tick
);

	localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;

	// Restart on clear so the first tick lands one full period later
	always_comb begin
		if (clr || cnt_q == LAST) begin
			cnt_d = '0;
		end else begin
			cnt_d = cnt_q + CW'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign tick = !clr && (cnt_q == LAST);

endmodule

/* rtl/lhsu_lin_sync.sv */
// LIN break detector and sync field timer with APB register access.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
module lhsu_lin_sync (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// LIN bus receive level
	input  wire logic        lin_rx,
	// Interrupt request to the system controller
	output logic             sync_irq
);

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Address match against one register word
	function automatic logic hit(input logic [31:0] a, input logic [31:0] base);
		hit = (a == base);
	endfunction

	// Four-bit edge count that sticks at its top value
	function automatic logic [3:0] sat_inc(input logic [3:0] v);
		sat_inc = (v == 4'hf) ? v : v + 4'h1;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State

	logic                 sy1_q, sy2_q, bus_p_q;
	logic [8:0]           ctrl_q, ctrl_d;
	logic [5:0]           sta_q, sta_d;
	logic [7:0]           ecfg_q, ecfg_d;
	logic [11:0]          bcmp_q, bcmp_d;
	logic [11:0]          btmr_q, btmr_d;
	logic [15:0]          stmr_q, stmr_d;
	logic [3:0]           fcnt_q, fcnt_d;
	logic [3:0]           rcnt_q, rcnt_d;
	logic                 bvalid_q, bvalid_d;
	logic                 irq_q, irq_d;
	logic [9:0]           sclr_q, sclr_d;
	lhsu_pkg::lhsu_state_e st_q, st_d;
	logic [31:0]          prdata_q, prdata_d;
	logic                 pready_q, pready_d;
	logic                 pslverr_q, pslverr_d;

	logic                 fall, rise, bus_low;
	logic                 sync_tick, brk_tick;
	logic                 run, match, ovf;
	logic                 setup, acc, wr, rd;
	logic [5:0]           sta_set, sta_clr;
	logic [3:0]           fnext, rnext, stop_next;

	////////////////////////////////////////////////////////////////////////////
	// Bus pin synchroniser; idle level is high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sy1_q   <= 1'b1;
			sy2_q   <= 1'b1;
			bus_p_q <= 1'b1;
		end else begin
			sy1_q   <= lin_rx;
			sy2_q   <= sy1_q;
			bus_p_q <= sy2_q;
		end
	end

	// Edges compare the second stage with the third
	assign fall    = bus_p_q && !sy2_q;
	assign rise    = !bus_p_q && sy2_q;
	assign bus_low = !sy2_q;

	////////////////////////////////////////////////////////////////////////////
	// Timer ticks derived from pclk, no second clock domain

	// Sync ticks restart whenever the sync timer is not running
	lhsu_tick_gen #(
		.DIV (lhsu_pkg::SYNC_DIV)
	) u_sync_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (st_q != lhsu_pkg::LHSU_SYNC_RUN),
		.tick    (sync_tick)
	);

	// Break ticks realign to each falling edge
	lhsu_tick_gen #(
		.DIV (lhsu_pkg::BRK_DIV)
	) u_brk_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (fall),
		.tick    (brk_tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// APB phase decode; zero wait states, answer in the first access cycle
	assign setup = psel && !penable;
	assign acc   = psel && penable && pready_q;
	assign wr    = acc && pwrite;
	assign rd    = acc && !pwrite;

	// Run only when enabled and not held by a reset or counter clear
	assign run = ctrl_q[lhsu_pkg::CTRL_EN_BIT] && !ctrl_q[lhsu_pkg::CTRL_RST_BIT]
		&& !ctrl_q[lhsu_pkg::CTRL_ECLR_BIT];

	// Compare and overflow are judged on the tick that would advance the timer
	assign match = run && brk_tick && bus_low && st_q != lhsu_pkg::LHSU_IDLE
		&& (12'(btmr_q + 12'h001) == bcmp_q);
	assign ovf   = run && brk_tick && bus_low && st_q == lhsu_pkg::LHSU_BREAK
		&& btmr_q == 12'hfff;

	assign fnext     = sat_inc(fcnt_q);
	assign rnext     = sat_inc(rcnt_q);
	assign stop_next = ctrl_q[lhsu_pkg::CTRL_POL_BIT] ? rnext : fnext;

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic for registers, timers and frame tracking
	always_comb begin
		ctrl_d    = ctrl_q;
		ecfg_d    = ecfg_q;
		bcmp_d    = bcmp_q;
		btmr_d    = btmr_q;
		stmr_d    = stmr_q;
		fcnt_d    = fcnt_q;
		rcnt_d    = rcnt_q;
		bvalid_d  = bvalid_q;
		st_d      = st_q;
		sclr_d    = sclr_q;
		irq_d     = 1'b0;
		sta_set   = '0;
		sta_clr   = '0;
		prdata_d  = prdata_q;
		pready_d  = setup;
		pslverr_d = 1'b0;

		// Register read data is sampled in the setup cycle
		if (setup) begin
			prdata_d = '0;
			if (!pwrite) begin
				if (hit(paddr, lhsu_pkg::ADDR_SYNC_CONTROL)) begin
					prdata_d[8:0] = ctrl_q;
				end else if (hit(paddr, lhsu_pkg::ADDR_SYNC_STATUS)) begin
					prdata_d[5:0] = sta_q;
				end else if (hit(paddr, lhsu_pkg::ADDR_SYNC_TIMER)) begin
					prdata_d[15:0] = stmr_q;
				end else if (hit(paddr, lhsu_pkg::ADDR_EDGE_CONFIG)) begin
					prdata_d[7:0] = ecfg_q;
				end else if (hit(paddr, lhsu_pkg::ADDR_BREAK_TIMER)) begin
					prdata_d[11:0] = btmr_q;
				end
			end
			pslverr_d = !(hit(paddr, lhsu_pkg::ADDR_SYNC_CONTROL)
				|| hit(paddr, lhsu_pkg::ADDR_SYNC_STATUS)
				|| hit(paddr, lhsu_pkg::ADDR_SYNC_TIMER)
				|| hit(paddr, lhsu_pkg::ADDR_EDGE_CONFIG)
				|| hit(paddr, lhsu_pkg::ADDR_BREAK_TIMER));
		end

		// Writes land at the access edge
		if (wr) begin
			if (hit(paddr, lhsu_pkg::ADDR_SYNC_CONTROL)) begin
				ctrl_d = pwdata[8:0];
			end
			if (hit(paddr, lhsu_pkg::ADDR_SYNC_STATUS)) begin
				sta_clr = pwdata[5:0];
			end
			if (hit(paddr, lhsu_pkg::ADDR_EDGE_CONFIG)) begin
				ecfg_d = pwdata[7:0];
			end
			if (hit(paddr, lhsu_pkg::ADDR_BREAK_TIMER)) begin
				bcmp_d = pwdata[11:0];
			end
		end

		// Frame tracking; break detection stays armed in every active state
		if (!run) begin
			st_d     = lhsu_pkg::LHSU_IDLE;
			fcnt_d   = '0;
			rcnt_d   = '0;
			bvalid_d = 1'b0;
			btmr_d   = '0;
		end else begin
			// Break timer clears on a falling edge, counts while low
			if (fall) begin
				btmr_d = '0;
			end else if (brk_tick && bus_low && st_q != lhsu_pkg::LHSU_IDLE) begin
				btmr_d = 12'(btmr_q + 12'h001);
			end

			case (st_q)
				lhsu_pkg::LHSU_IDLE: begin
					if (fall) begin
						st_d     = lhsu_pkg::LHSU_BREAK;
						fcnt_d   = 4'h1;
						rcnt_d   = '0;
						bvalid_d = 1'b0;
					end
				end
				lhsu_pkg::LHSU_BREAK: begin
					if (ovf) begin
						// Bus stuck low: give up on this frame
						st_d              = lhsu_pkg::LHSU_IDLE;
						sta_set[lhsu_pkg::STA_BFE_BIT] = 1'b1;
						irq_d             = 1'b1;
					end else if (rise) begin
						rcnt_d = rnext;
						// Short lows are data bits, not a break
						st_d = bvalid_q ? lhsu_pkg::LHSU_SYNC_WAIT : lhsu_pkg::LHSU_IDLE;
					end
				end
				lhsu_pkg::LHSU_SYNC_WAIT: begin
					if (rise) begin
						rcnt_d = rnext;
					end
					if (fall) begin
						fcnt_d = fnext;
						if (fnext >= ecfg_q[lhsu_pkg::START_MSB:lhsu_pkg::START_LSB]) begin
							st_d   = lhsu_pkg::LHSU_SYNC_RUN;
							stmr_d = '0;
							sta_set[lhsu_pkg::STA_START_BIT] = 1'b1;
						end
					end
				end
				lhsu_pkg::LHSU_SYNC_RUN: begin
					if (sync_tick) begin
						stmr_d = 16'(stmr_q + 16'h0001);
					end
					if (rise) begin
						rcnt_d = rnext;
					end
					if (fall) begin
						fcnt_d = fnext;
					end
					// Stopped value stays in the timer for software
					if ((ctrl_q[lhsu_pkg::CTRL_POL_BIT] ? rise : fall)
						&& stop_next >= ecfg_q[lhsu_pkg::STOP_MSB:lhsu_pkg::STOP_LSB]) begin
						st_d = lhsu_pkg::LHSU_IDLE;
						sta_set[lhsu_pkg::STA_STOP_BIT] = 1'b1;
						// A stop fall may open the next break, so arm break timing on it
						if (fall) begin
							st_d     = lhsu_pkg::LHSU_BREAK;
							fcnt_d   = 4'h1;
							rcnt_d   = '0;
							bvalid_d = 1'b0;
						end
					end
				end
				default: begin
					st_d = lhsu_pkg::LHSU_IDLE;
				end
			endcase

			// A match in any active state marks a valid break
			if (match) begin
				sta_set[lhsu_pkg::STA_BREAK_BIT] = 1'b1;
				irq_d    = 1'b1;
				bvalid_d = 1'b1;
				if (st_q != lhsu_pkg::LHSU_BREAK) begin
					// New break during sync or data restarts the frame
					st_d   = lhsu_pkg::LHSU_BREAK;
					fcnt_d = 4'h1;
					rcnt_d = '0;
				end
			end
		end

		// Reading the break timer restarts it
		if (rd && hit(paddr, lhsu_pkg::ADDR_BREAK_TIMER)) begin
			btmr_d = '0;
		end

		// Reset and counter clear bits hold for 15 us then drop themselves
		if (ctrl_q[lhsu_pkg::CTRL_RST_BIT] || ctrl_q[lhsu_pkg::CTRL_ECLR_BIT]) begin
			if (sclr_q == 10'(lhsu_pkg::SELF_CLR_CYC - 1)) begin
				sclr_d = '0;
				ctrl_d[lhsu_pkg::CTRL_RST_BIT]  = 1'b0;
				ctrl_d[lhsu_pkg::CTRL_ECLR_BIT] = 1'b0;
				sta_set[lhsu_pkg::STA_RDONE_BIT] = ctrl_q[lhsu_pkg::CTRL_RST_BIT];
			end else begin
				sclr_d = 10'(sclr_q + 10'h001);
			end
		end else begin
			sclr_d = '0;
		end

		// Soft reset returns everything to defaults but its own countdown and the other control bits
		if (ctrl_q[lhsu_pkg::CTRL_RST_BIT]) begin
			ecfg_d = lhsu_pkg::EDGE_CONFIG_RST;
			bcmp_d = lhsu_pkg::BREAK_CMP_RST;
			stmr_d = '0;
			btmr_d = '0;
			irq_d  = 1'b0;
		end

		// Hardware set wins over a write-one clear in the same cycle
		sta_d = (sta_q & ~sta_clr) | sta_set;
		if (ctrl_q[lhsu_pkg::CTRL_RST_BIT]) begin
			sta_d = sta_set;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q    <= lhsu_pkg::CONTROL_RST;
			sta_q     <= lhsu_pkg::STATUS_RST;
			ecfg_q    <= lhsu_pkg::EDGE_CONFIG_RST;
			bcmp_q    <= lhsu_pkg::BREAK_CMP_RST;
			btmr_q    <= '0;
			stmr_q    <= '0;
			fcnt_q    <= '0;
			rcnt_q    <= '0;
			bvalid_q  <= 1'b0;
			irq_q     <= 1'b0;
			sclr_q    <= '0;
			st_q      <= lhsu_pkg::LHSU_IDLE;
			prdata_q  <= '0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			ctrl_q    <= ctrl_d;
			sta_q     <= sta_d;
			ecfg_q    <= ecfg_d;
			bcmp_q    <= bcmp_d;
			btmr_q    <= btmr_d;
			stmr_q    <= stmr_d;
			fcnt_q    <= fcnt_d;
			rcnt_q    <= rcnt_d;
			bvalid_q  <= bvalid_d;
			irq_q     <= irq_d;
			sclr_q    <= sclr_d;
			st_q      <= st_d;
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata   = prdata_q;
	assign pready   = pready_q;
	assign pslverr  = pslverr_q;
	assign sync_irq = irq_q;

endmodule

/* sim/lhsu_lin_sync_chk.sv */
// Concurrent checks on the LIN sync unit ports.
`timescale 1ns/10ps
module lhsu_lin_sync_chk (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB slave
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// LIN side
	input wire logic        lin_rx,
	input wire logic        sync_irq
);
	logic setup;
	logic acc;
	logic mapped;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	////////////////////////////////////////
	// Transfer phases and the five decoded words
	assign setup = psel && !penable;
	assign acc = psel && penable && pready;
	assign mapped = paddr inside {lhsu_pkg::ADDR_SYNC_CONTROL, lhsu_pkg::ADDR_SYNC_STATUS,
		lhsu_pkg::ADDR_SYNC_TIMER, lhsu_pkg::ADDR_EDGE_CONFIG, lhsu_pkg::ADDR_BREAK_TIMER};

	// Multi-step reads and writes, one idle cycle apart as the bench drives them
	sequence rd_s(logic [31:0] a);
		setup && !pwrite && paddr == a ##1 acc;
	endsequence
	sequence cfg_wr_s;
		acc && pwrite && paddr == lhsu_pkg::ADDR_EDGE_CONFIG;
	endsequence

	a_ready_after_setup: assert property (setup |=> acc ##1 !pready)
		else $error("pready not one pulse after setup");
	a_err_unmapped: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_cfg_readback: assert property
		(cfg_wr_s ##2 rd_s(lhsu_pkg::ADDR_EDGE_CONFIG) |-> prdata == {24'h0, $past(pwdata[7:0], 3)})
		else $error("edge config read differs from write");
	a_brk_rd_clears: assert property
		(rd_s(lhsu_pkg::ADDR_BREAK_TIMER) ##2 rd_s(lhsu_pkg::ADDR_BREAK_TIMER) |-> prdata <= 32'h1)
		else $error("break timer not cleared by read");
	a_brk_rd_width: assert property
		(acc && !pwrite && paddr == lhsu_pkg::ADDR_BREAK_TIMER |-> prdata[31:12] == 20'h0)
		else $error("break timer wider than 12 bits");
	a_sync_rd_width: assert property
		(acc && !pwrite && paddr == lhsu_pkg::ADDR_SYNC_TIMER |-> prdata[31:16] == 16'h0)
		else $error("sync timer wider than 16 bits");
	a_irq_one_pulse: assert property (sync_irq |=> !sync_irq)
		else $error("interrupt request longer than one cycle");
	a_irq_bus_low: assert property (sync_irq |-> !$past(lin_rx, 6))
		else $error("interrupt request while bus high");
endmodule

bind lhsu_lin_sync lhsu_lin_sync_chk lhsu_lin_sync_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .lin_rx(lin_rx), .sync_irq(sync_irq));

/* sim/lhsu_lin_master.sv */
// Behavioural LIN master node sending break, delimiter and sync field.
`timescale 1ns/10ps
module lhsu_lin_master (
	// Clock
	input  wire logic        pclk,
	// Frame request
	input  wire logic        go,
	input  wire logic [15:0] brk_cyc,
	input  wire logic [15:0] bit_cyc,
	// Bus level and activity
	output logic             lin,
	output logic             busy
);
	logic [15:0] cnt_q;
	logic [10:0] pat_q;
	logic [3:0]  slot_q;

	////////////////////////////////////////
	// Bus idles high through the pull-up, so a released line reads one
	initial begin
		lin = 1'b1;
		busy = 1'b0;
	end

	// Break stretched to 13 bit times at least, then delimiter and 0x55 framed LSB first
	always @(posedge pclk) begin
		if (go && !busy) begin
			busy <= 1'b1;
			lin <= 1'b0;
			cnt_q <= (brk_cyc < 16'(13 * bit_cyc)) ? 16'(13 * bit_cyc) : brk_cyc;
			pat_q <= 11'h555;
			slot_q <= 4'h0;
		end else if (busy && cnt_q > 16'h1) begin
			cnt_q <= cnt_q - 16'h1;
		end else if (busy && slot_q != 4'hb) begin
			lin <= pat_q[0];
			pat_q <= pat_q >> 1;
			slot_q <= slot_q + 4'h1;
			cnt_q <= bit_cyc;
		end else begin
			busy <= 1'b0;
		end
	end
endmodule

/* sim/tb.sv */
// Self-checking bench for the LIN break and sync timing unit.
`timescale 1ns/10ps
module tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, lin_rx, sync_irq, go, busy;
	logic [31:0] paddr, pwdata, prdata;
	logic [15:0] brk_cyc;
	int          n_mismatch, n_compared, n_irq;

	lhsu_lin_sync lhsu_lin_sync_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .lin_rx(lin_rx), .sync_irq(sync_irq));
	// Bit time of 160 cycles keeps sync counts small but well above tick jitter
	lhsu_lin_master lhsu_lin_master_inst (.pclk(pclk), .go(go), .brk_cyc(brk_cyc), .bit_cyc(16'd160),
		.lin(lin_rx), .busy(busy));

	////////////////////////////////////////
	// 40 MHz clock and interrupt pulse counter
	always #12.5 pclk = ~pclk;
	always @(posedge pclk) begin
		if (sync_irq === 1'b1) begin
			n_irq++;
		end
	end

	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Ends the run when a bounded wait is used up
	task automatic guard(input int k, lim);
		if (k >= lim) begin
			n_mismatch++;
			finish_test();
		end
	endtask

	task automatic chk(input logic [31:0] got, lo, hi);
		n_compared++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask

	// One APB transfer; always leaves an idle cycle so strobes never toggle twice in a step
	task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] r, output logic e);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		guard(k, 20);
	endtask

	task automatic wr(input logic [31:0] a, d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rdc(input logic [31:0] a, lo, hi);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, lo, hi);
	endtask

	task automatic launch(input logic [15:0] b);
		brk_cyc <= b;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
	endtask

	task automatic settle();
		int k;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (busy !== 1'b0 && k < 30000);
		guard(k, 30000);
		repeat (50) @(posedge pclk);
	endtask

	// Full frame with a break match; checks one pulse, status and captured count
	task automatic meas(input logic [7:0] cfg, ctl, input logic [15:0] b, input logic [31:0] lo, hi);
		int n0;
		wr(lhsu_pkg::ADDR_EDGE_CONFIG, {24'h0, cfg});
		wr(lhsu_pkg::ADDR_SYNC_CONTROL, {24'h0, ctl});
		wr(lhsu_pkg::ADDR_SYNC_STATUS, 32'h3f);
		n0 = n_irq;
		launch(b);
		settle();
		chk(32'(n_irq - n0), 32'h1, 32'h1);
		rdc(lhsu_pkg::ADDR_SYNC_STATUS, 32'h7, 32'h7);
		rdc(lhsu_pkg::ADDR_SYNC_TIMER, lo, hi);
	endtask

	task automatic s_regs();
		logic [31:0] r;
		logic        e;
		rdc(lhsu_pkg::ADDR_EDGE_CONFIG, 32'h32, 32'h32);
		rdc(lhsu_pkg::ADDR_BREAK_TIMER, 32'h0, 32'h0);
		wr(lhsu_pkg::ADDR_SYNC_TIMER, 32'hffff);
		rdc(lhsu_pkg::ADDR_SYNC_TIMER, 32'h0, 32'h0);
		wr(lhsu_pkg::ADDR_EDGE_CONFIG, 32'ha5);
		rdc(lhsu_pkg::ADDR_EDGE_CONFIG, 32'ha5, 32'ha5);
		apb(1'b0, 32'hffff07a0, 32'h0, r, e);
		chk({31'h0, e}, 32'h1, 32'h1);
	endtask

	// Break too short for the compare: timer reads, clears, and no sync timing
	task automatic s_break();
		int n0;
		// Short start and stop counts, so a wrongful timing run would change the held value
		wr(lhsu_pkg::ADDR_EDGE_CONFIG, 32'h32);
		wr(lhsu_pkg::ADDR_SYNC_STATUS, 32'h3f);
		n0 = n_irq;
		launch(16'd4000);
		repeat (3000) @(posedge pclk);
		rdc(lhsu_pkg::ADDR_BREAK_TIMER, 32'h8, 32'ha);
		rdc(lhsu_pkg::ADDR_BREAK_TIMER, 32'h0, 32'h1);
		wr(lhsu_pkg::ADDR_BREAK_TIMER, 32'h47);
		repeat (700) @(posedge pclk);
		rdc(lhsu_pkg::ADDR_BREAK_TIMER, 32'h1, 32'h3);
		settle();
		chk(32'(n_irq - n0), 32'h0, 32'h0);
		rdc(lhsu_pkg::ADDR_SYNC_STATUS, 32'h0, 32'h0);
		rdc(lhsu_pkg::ADDR_SYNC_TIMER, 32'd158, 32'd162);
	endtask

	// Enable cleared: a matching frame raises nothing
	task automatic s_off();
		int n0;
		wr(lhsu_pkg::ADDR_SYNC_CONTROL, 32'h0);
		wr(lhsu_pkg::ADDR_SYNC_STATUS, 32'h3f);
		n0 = n_irq;
		launch(16'd2400);
		settle();
		chk(32'(n_irq - n0), 32'h0, 32'h0);
		rdc(lhsu_pkg::ADDR_SYNC_STATUS, 32'h0, 32'h0);
	endtask

	// Stop count never reached: sync timing is left running when the next break comes
	task automatic s_open();
		wr(lhsu_pkg::ADDR_EDGE_CONFIG, 32'hf2);
		wr(lhsu_pkg::ADDR_SYNC_STATUS, 32'h3f);
		launch(16'd2400);
		settle();
		rdc(lhsu_pkg::ADDR_SYNC_STATUS, 32'h3, 32'h3);
	endtask

	task automatic s_soft();
		time         t0;
		int          k;
		logic [31:0] r;
		logic        e;
		wr(lhsu_pkg::ADDR_EDGE_CONFIG, 32'h77);
		wr(lhsu_pkg::ADDR_SYNC_CONTROL, 32'h1);
		t0 = $time;
		k = 0;
		do begin
			apb(1'b0, lhsu_pkg::ADDR_SYNC_STATUS, 32'h0, r, e);
			k++;
		end while (r[5] !== 1'b1 && k < 400);
		guard(k, 400);
		chk(32'(($time - t0) / 25), 32'd590, 32'd700);
		rdc(lhsu_pkg::ADDR_EDGE_CONFIG, 32'h32, 32'h32);
		rdc(lhsu_pkg::ADDR_SYNC_CONTROL, 32'h0, 32'h0);
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		go = 1'b0;
		brk_cyc = 16'h0;
		n_mismatch = 0;
		n_compared = 0;
		n_irq = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		s_regs();
		meas(8'h62, 8'h02, 16'd22500, 32'd158, 32'd162);
		s_break();
		wr(lhsu_pkg::ADDR_BREAK_TIMER, 32'h4);
		s_open();
		meas(8'h32, 8'h02, 16'd2400, 32'd38, 32'd42);
		meas(8'h32, 8'h82, 16'd2400, 32'd58, 32'd62);
		s_off();
		s_soft();
		finish_test();
	end
endmodule
